/* rtl/ccko_pkg.sv */
// Shared constants, types and reset values for the configuration clock output block
package ccko_pkg;

  // Widths of the memory side
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;

  // System clock rate and internal oscillator half period
  localparam int CLK_KHZ     = 10_000;
  localparam int OSC_HALF_NS = 250;
  // Least time, so round up to whole cycles, never below one
  localparam int OSC_HALF_RAW = (OSC_HALF_NS * CLK_KHZ + 999_999) / 1_000_000;
  localparam int OSC_HALF_CYC = (OSC_HALF_RAW < 1) ? 1 : OSC_HALF_RAW;
  localparam int OSC_CW       = 4;

  // Test access port instruction register
  localparam int             IR_W       = 4;
  localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
  localparam logic [IR_W-1:0] IR_CTRL    = 4'h2;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // Programmable control bits reached through the test access port
  typedef struct packed {
    logic decomp_en;
    logic sel_ext;
    logic clk_en;
  } ccko_ctrl_s;
  localparam int         CTRL_W   = 3;
  localparam ccko_ctrl_s CTRL_RST = 3'h0;

  // Sixteen-state test access port sequence, one-hot
  typedef enum logic [15:0] {
    TS_RESET  = 16'h0001,
    TS_IDLE   = 16'h0002,
    TS_SEL_DR = 16'h0004,
    TS_CAP_DR = 16'h0008,
    TS_SH_DR  = 16'h0010,
    TS_EX1_DR = 16'h0020,
    TS_PAU_DR = 16'h0040,
    TS_EX2_DR = 16'h0080,
    TS_UPD_DR = 16'h0100,
    TS_SEL_IR = 16'h0200,
    TS_CAP_IR = 16'h0400,
    TS_SH_IR  = 16'h0800,
    TS_EX1_IR = 16'h1000,
    TS_PAU_IR = 16'h2000,
    TS_EX2_IR = 16'h4000,
    TS_UPD_IR = 16'h8000
  } ccko_tap_e;

  // State of the test access port module
  typedef struct packed {
    ccko_tap_e        state;
    logic [IR_W-1:0]  ir;
    logic [IR_W-1:0]  ir_sh;
    ccko_ctrl_s       dr_sh;
    logic             bypass;
    ccko_ctrl_s       ctrl;
    logic             tdo;
    logic             tdo_oe_n;
  } ccko_tap_s;
  localparam ccko_tap_s TAP_RST = '{state: TS_RESET, ir: IR_BYPASS, ir_sh: IR_BYPASS,
                                    dr_sh: CTRL_RST, bypass: 1'b0, ctrl: CTRL_RST,
                                    tdo: 1'b1, tdo_oe_n: 1'b1};

  // State of the main clock-output module
  typedef struct packed {
    logic              ce_n_s1;
    logic              ce_n_s2;
    logic              oe_s1;
    logic              oe_s2;
    logic              ck_s1;
    logic              ck_s2;
    ccko_ctrl_s        ctl_s1;
    ccko_ctrl_s        ctl_s2;
    logic              src_prev;
    logic [OSC_CW-1:0] osc_cnt;
    logic              osc_lvl;
    logic              clk_out;
    logic              clk_oe_n;
    logic [DATA_W-1:0] data;
    logic              data_oe_n;
    logic [ADDR_W-1:0] addr;
    logic              standby;
  } ccko_main_s;
  localparam ccko_main_s MAIN_RST = '{ce_n_s1: 1'b1, ce_n_s2: 1'b1, clk_out: 1'b1, clk_oe_n: 1'b1,
                                      data_oe_n: 1'b1, standby: 1'b1, default: '0};

endpackage

/* rtl/ccko_tap.sv */
// Test access port controller on the test clock, holding the programmable control bits
module ccko_tap (
  input  wire logic               tck_i,
  input  wire logic               arst_n_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  output      logic               tdo_o,
  output      logic               tdo_oe_n_o,
  output      ccko_pkg::ccko_ctrl_s ctrl_o
);
  import ccko_pkg::*;

  ccko_tap_s q;
  ccko_tap_s d;

  // Standard transition table, decided by the mode-select value on each edge
  function automatic ccko_tap_e tap_next(input ccko_tap_e s, input logic m);
    ccko_tap_e n;
    n = TS_RESET;
    unique case (s)
      TS_RESET:  n = m ? TS_RESET  : TS_IDLE;
      TS_IDLE:   n = m ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: n = m ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: n = m ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR:  n = m ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: n = m ? TS_UPD_DR : TS_PAU_DR;
      TS_PAU_DR: n = m ? TS_EX2_DR : TS_PAU_DR;
      TS_EX2_DR: n = m ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: n = m ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: n = m ? TS_RESET  : TS_CAP_IR;
      TS_CAP_IR: n = m ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR:  n = m ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: n = m ? TS_UPD_IR : TS_PAU_IR;
      TS_PAU_IR: n = m ? TS_EX2_IR : TS_PAU_IR;
      TS_EX2_IR: n = m ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: n = m ? TS_SEL_DR : TS_IDLE;
      default:   n = TS_RESET;
    endcase
    return n;
  endfunction

  // Next state; capture, shift and update of the selected register
  always_comb begin
    d       = q;
    d.state = tap_next(q.state, tms_i);
    unique case (q.state)
      TS_RESET:  d.ir = IR_BYPASS;
      TS_CAP_IR: d.ir_sh = IR_CAPTURE;
      TS_SH_IR:  d.ir_sh = {tdi_i, q.ir_sh[IR_W-1:1]};
      TS_UPD_IR: d.ir = q.ir_sh;
      TS_CAP_DR: begin
        d.dr_sh  = q.ctrl;
        d.bypass = 1'b0;
      end
      TS_SH_DR: begin
        if (q.ir == IR_CTRL) begin
          d.dr_sh = {tdi_i, q.dr_sh[CTRL_W-1:1]};
        end else begin
          d.bypass = tdi_i;
        end
      end
      TS_UPD_DR: begin
        if (q.ir == IR_CTRL) begin
          d.ctrl = q.dr_sh;
        end
      end
      default: ;
    endcase
    // Present the bit that the next shift edge will move, so it is valid on entry
    if (d.state == TS_SH_IR) begin
      d.tdo = d.ir_sh[0];
    end else if (q.ir == IR_CTRL) begin
      d.tdo = d.dr_sh[0];
    end else begin
      d.tdo = d.bypass;
    end
    d.tdo_oe_n = !(d.state == TS_SH_IR || d.state == TS_SH_DR);
  end

  // Everything here runs on the test clock alone
  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= TAP_RST;
    end else begin
      q <= d;
    end
  end

  assign tdo_o      = q.tdo;
  assign tdo_oe_n_o = q.tdo_oe_n;
  assign ctrl_o     = q.ctrl;

  default clocking cb @(posedge tck_i); endclocking
  default disable iff (!arst_n_i);

  a_tap_five_high: assert property (tms_i [*5] |=> q.state == TS_RESET)
    else $error("Five high mode-select clocks did not reach reset");
  a_tap_tms_hold: assert property (q.state == TS_IDLE && !tms_i |=> q.state == TS_IDLE)
    else $error("Idle left with mode-select low");
  a_tdi_shift_in: assert property (q.state == TS_SH_IR |=> q.ir_sh[IR_W-1] == $past(tdi_i))
    else $error("Test data input not shifted into instruction register");
  a_tdo_ctrl_bit: assert property (q.state == TS_SH_DR && q.ir == IR_CTRL |-> tdo_o == q.dr_sh[0] && !tdo_oe_n_o)
    else $error("Test data output does not show control shift bit");
  c_tap_upd_ctrl: cover property (q.state == TS_UPD_DR && q.ir == IR_CTRL);
endmodule

/* rtl/ccko_top.sv */
// Configuration clock output, address advance and output gating for the configuration memory
module ccko_top (
  input  wire logic                           clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic                           ce_n_i,
  input  wire logic                           oe_reset_i,
  input  wire logic                           clk_pin_i,
  input  wire logic                           data_avail_i,
  input  wire logic                           decomp_ready_i,
  input  wire logic [ccko_pkg::DATA_W-1:0]    mem_data_i,
  input  wire logic                           tck_i,
  input  wire logic                           tms_i,
  input  wire logic                           tdi_i,
  output      logic                           tdo_o,
  output      logic                           tdo_oe_n_o,
  output      logic [ccko_pkg::ADDR_W-1:0]    addr_o,
  output      logic [ccko_pkg::DATA_W-1:0]    data_o,
  output      logic                           data_oe_n_o,
  output      logic                           cfg_clock_out_o,
  output      logic                           cfg_clock_out_oe_n_o,
  output      logic                           standby_o
);
  import ccko_pkg::*;

  ccko_main_s q;
  ccko_main_s d;
  ccko_ctrl_s tap_ctrl;
  logic       src;
  logic       rise;
  logic       en_out;
  logic       parked;
  logic       advance;

  // Test access port lives entirely in the test clock domain
  ccko_tap u_tap (
    .tck_i      (tck_i),
    .arst_n_i   (arst_n_i),
    .tms_i      (tms_i),
    .tdi_i      (tdi_i),
    .tdo_o      (tdo_o),
    .tdo_oe_n_o (tdo_oe_n_o),
    .ctrl_o     (tap_ctrl)
  );

  // Source choice, edge detect and the gating terms, from synchronised levels except data_avail_i and decomp_ready_i
  always_comb begin
    src     = q.ctl_s2.sel_ext ? q.ck_s2 : q.osc_lvl;
    rise    = src && !q.src_prev;
    en_out  = q.ctl_s2.clk_en && !q.ce_n_s2 && q.oe_s2;
    parked  = q.ctl_s2.decomp_en && !decomp_ready_i;
    advance = rise && data_avail_i && !q.ce_n_s2 && q.oe_s2 && !parked;
  end

  // Next state of the whole module
  always_comb begin
    d = q;
    // Chip enable, output-enable/reset and clock pins and the slow control bits pass two flops before use
    d.ce_n_s1 = ce_n_i;
    d.ce_n_s2 = q.ce_n_s1;
    d.oe_s1   = oe_reset_i;
    d.oe_s2   = q.oe_s1;
    d.ck_s1   = clk_pin_i;
    d.ck_s2   = q.ck_s1;
    d.ctl_s1  = tap_ctrl;
    d.ctl_s2  = q.ctl_s1;
    d.src_prev = src;
    // Internal oscillator, a free divider of the system clock
    if (q.osc_cnt == OSC_CW'(OSC_HALF_CYC - 1)) begin
      d.osc_cnt = '0;
      d.osc_lvl = !q.osc_lvl;
    end else begin
      d.osc_cnt = q.osc_cnt + OSC_CW'(1);
    end
    // Clock output: released when off, held high while decompression lags
    if (!en_out) begin
      d.clk_oe_n = 1'b1;
      d.clk_out  = 1'b1;
    end else if (parked) begin
      d.clk_oe_n = 1'b0;
      d.clk_out  = 1'b1;
    end else begin
      d.clk_oe_n = 1'b0;
      d.clk_out  = src;
    end
    // Address and data; a low output-enable/reset also rewinds the counter
    if (q.ce_n_s2) begin
      d.addr      = '0;
      d.standby   = 1'b1;
      d.data_oe_n = 1'b1;
    end else if (!q.oe_s2) begin
      d.addr      = '0;
      d.standby   = 1'b0;
      d.data_oe_n = 1'b1;
    end else begin
      d.standby   = 1'b0;
      d.data_oe_n = 1'b0;
      if (advance) begin
        d.addr = q.addr + ADDR_W'(1);
        d.data = mem_data_i;
      end
    end
  end

  // Single state register; data and clock-out rise land on the same edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= MAIN_RST;
    end else begin
      q <= d;
    end
  end

  assign addr_o               = q.addr;
  assign data_o               = q.data;
  assign data_oe_n_o          = q.data_oe_n;
  assign cfg_clock_out_o      = q.clk_out;
  assign cfg_clock_out_oe_n_o = q.clk_oe_n;
  assign standby_o            = q.standby;

  default clocking mcb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_clk_off_hiz: assert property (!en_out |=> cfg_clock_out_oe_n_o)
    else $error("Clock output driven while disabled");
  a_clk_on_drive: assert property (en_out |=> !cfg_clock_out_oe_n_o)
    else $error("Clock output released while enabled");
  a_ce_high_idle: assert property (q.ce_n_s2 |=> addr_o == '0 && data_oe_n_o && cfg_clock_out_oe_n_o && standby_o)
    else $error("Chip enable high did not idle the outputs");
  a_addr_step_one: assert property (advance |=> addr_o == $past(addr_o) + ADDR_W'(1))
    else $error("Address did not advance by one");
  a_addr_hold_still: assert property (!advance && !q.ce_n_s2 && q.oe_s2 |=> $stable(addr_o))
    else $error("Address moved without a source edge");
  a_park_high_out: assert property (en_out && parked |=> cfg_clock_out_o && !cfg_clock_out_oe_n_o)
    else $error("Clock output not parked high");
  a_src_follow: assert property (en_out && !parked |=> cfg_clock_out_o == $past(src))
    else $error("Clock output does not follow selected source");
  // Only a driven, low clock output can rise with the data; a disabled one still steps the address
  a_data_on_rise: assert property (advance && en_out && !cfg_clock_out_o |=> $rose(cfg_clock_out_o) && data_o == $past(mem_data_i))
    else $error("New data not aligned with clock output rise");

  c_advance_ext: cover property (advance && q.ctl_s2.sel_ext);
  c_advance_osc: cover property (advance && !q.ctl_s2.sel_ext);
  c_parked: cover property (en_out && parked [*3]);
  c_ce_release: cover property (q.ce_n_s2 ##1 !q.ce_n_s2);
endmodule

/* testbench/ccko_rx_model.sv */
// Receiving logic model: samples configuration data on clock output rises
module ccko_rx_model (
  input  wire logic                        clk_line_i,
  input  wire logic                        clk_oe_n_i,
  input  wire logic [ccko_pkg::DATA_W-1:0] data_i,
  input  wire logic                        data_oe_n_i,
  output      logic [ccko_pkg::DATA_W-1:0] word_o,
  output      logic                        got_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // External pull-up holds the line high once the block lets go of it
  wire logic line = clk_oe_n_i ? 1'b1 : clk_line_i;
  initial got_o = 1'b0;
  // Sample just after the rise, only while both lines are driven
  always @(posedge line) begin
    #1;
    if (!clk_oe_n_i && !data_oe_n_i) begin
      word_o = data_i;
      got_o = ~got_o;
    end
  end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the configuration clock output block
module testbench;
  import ccko_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, tck_i = 0, arst_n_i = 0, ce_n_i = 1, oe_reset_i = 1, pin_run = 0;
  logic clk_pin_i = 0, data_avail_i = 0, decomp_ready_i = 1, tms_i = 1, tdi_i = 1, chk = 0;
  logic tdo_o, tdo_oe_n_o, data_oe_n_o, cfg_clock_out_o, cfg_clock_out_oe_n_o, standby_o, tdo_s, got;
  logic [ADDR_W-1:0] addr_o;
  logic [DATA_W-1:0] data_o, word, mem [0:63];
  logic [DATA_W-1:0] exp_q [$];
  int num_errors = 0, comparisons = 0, seed = 22054, ncap = 0;
  // Memory array model looked up by the block's address
  wire logic [DATA_W-1:0] mem_data_i = mem[addr_o[5:0]];

  always #50 clk_i = ~clk_i;
  always #32 tck_i = ~tck_i;
  // External clock pin with random spacing, held low when not in use
  always begin
    repeat (2 + {$random(seed)} % 4) @(posedge clk_i);
    #2 clk_pin_i = pin_run & ~clk_pin_i;
  end

  ccko_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_n_i(ce_n_i), .oe_reset_i(oe_reset_i),
    .clk_pin_i(clk_pin_i), .data_avail_i(data_avail_i), .decomp_ready_i(decomp_ready_i),
    .mem_data_i(mem_data_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
    .tdo_oe_n_o(tdo_oe_n_o), .addr_o(addr_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .cfg_clock_out_o(cfg_clock_out_o), .cfg_clock_out_oe_n_o(cfg_clock_out_oe_n_o),
    .standby_o(standby_o));
  ccko_rx_model rx_u (.clk_line_i(cfg_clock_out_o), .clk_oe_n_i(cfg_clock_out_oe_n_o),
    .data_i(data_o), .data_oe_n_i(data_oe_n_o), .word_o(word), .got_o(got));

  task automatic check(input logic [31:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  // One test clock: mode-select and data set well before the rise
  task automatic jb(input logic m, d);
    tms_i = m;
    tdi_i = d;
    tdo_s = tdo_o;
    @(posedge tck_i);
    #2;
  endtask

  task automatic jseq(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) jb(m[i], 1'b1);
  endtask

  // Load the control instruction, then write v while reading back the old bits
  task automatic wctl(input logic [2:0] v, old);
    logic [3:0] ir_seen;
    logic [2:0] dr_seen;
    jseq(8'b0011, 4);
    for (int i = 0; i < 4; i++) begin
      jb(i == 3, IR_CTRL[i]);
      ir_seen[i] = tdo_s;
    end
    jseq(8'b0011, 4);
    for (int i = 0; i < 3; i++) begin
      jb(i == 2, v[i]);
      dr_seen[i] = tdo_s;
    end
    jseq(8'b01, 2);
    check(ir_seen, IR_CAPTURE, "instruction capture");
    check(dr_seen, old, "control readback");
    cyc(6);
  endtask

  // Fresh expectations: the address restarts at zero
  task automatic arm;
    exp_q.delete();
    ncap = 0;
    foreach (mem[i]) exp_q.push_back(mem[i]);
  endtask

  task automatic wait_cap(input int n, lim);
    for (int i = 0; i < lim && ncap < n; i++) cyc(1);
    if (ncap < n) begin
      check(ncap, n, "capture timeout");
      report_and_stop();
    end
  endtask

  // Each capture is matched against the oldest expected word
  always @(got) begin
    if (arst_n_i && chk) begin
      if (exp_q.size() == 0) check(1, 0, "unexpected capture");
      else check(word, exp_q.pop_front(), "captured word");
      check(addr_o, ++ncap, "address step");
    end
  end

  initial begin
    logic [ADDR_W-1:0] a;
    foreach (mem[i]) mem[i] = $random(seed);
    cyc(2);
    arst_n_i = 1;
    check({cfg_clock_out_oe_n_o, data_oe_n_o, standby_o, tdo_oe_n_o}, 4'hF, "reset outputs");
    check(addr_o, 0, "reset address");
    @(posedge tck_i);
    #2;
    jb(0, 1);
    wctl(3'b001, 3'b000);
    ce_n_i = 0;
    data_avail_i = 1;
    arm();
    chk = 1;
    wait_cap(6, 300);
    check(cfg_clock_out_oe_n_o, 0, "clock driven");
    $display("test internal source done");
    chk = 0;
    data_avail_i = 0;
    cyc(3);
    a = addr_o;
    cyc(20);
    check(addr_o, a, "no step without data");
    oe_reset_i = 0;
    cyc(4);
    check({cfg_clock_out_oe_n_o, data_oe_n_o}, 2'b11, "released on reset pin");
    oe_reset_i = 1;
    data_avail_i = 1;
    ce_n_i = 1;
    cyc(4);
    check({standby_o, cfg_clock_out_oe_n_o, data_oe_n_o}, 3'b111, "standby outputs");
    check(addr_o, 0, "standby address");
    $display("test gating done");
    wctl(3'b011, 3'b001);
    pin_run = 1;
    arm();
    chk = 1;
    ce_n_i = 0;
    wait_cap(5, 600);
    pin_run = 0;
    chk = 0;
    ce_n_i = 1;
    $display("test pin source done");
    wctl(3'b101, 3'b011);
    decomp_ready_i = 0;
    ce_n_i = 0;
    cyc(30);
    check({cfg_clock_out_o, cfg_clock_out_oe_n_o}, 2'b10, "parked high");
    check(addr_o, 0, "no step while parked");
    arm();
    chk = 1;
    decomp_ready_i = 1;
    wait_cap(3, 300);
    chk = 0;
    ce_n_i = 1;
    $display("test decompression done");
    wctl(3'b000, 3'b101);
    ce_n_i = 0;
    cyc(20);
    check(cfg_clock_out_oe_n_o, 1, "clock off without enable bit");
    jseq(8'b0001_1111, 6);
    jseq(8'b001, 3);
    jb(0, 1);
    check(tdo_s, 0, "bypass capture after test reset");
    jb(1, 0);
    check(tdo_s, 1, "bypass shifted bit");
    jseq(8'b01, 2);
    $display("test port reset done");
    report_and_stop();
  end
endmodule
